// [ass_pkg.sv]
package ass_pkg;
  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS   = 16;        // Every command frame is sixteen bits
  localparam int CMD_MSB      = 15;        // Command field top bit
  localparam int CMD_LSB      = 13;        // Command field low bit
  localparam int ADDR_MSB     = 12;        // Register address top bit
  localparam int ADDR_LSB     = 8;         // Register address low bit
  localparam int VAL_MSB      = 7;         // Register value top bit
  localparam logic [2:0] CMD_READ  = 3'h2; // Read register command
  localparam logic [2:0] CMD_WRITE = 3'h4; // Write register command
  // ---------------------------------------------------------------
  // Angle path
  // ---------------------------------------------------------------
  localparam int ANGLE_BITS   = 14;        // Useful angle resolution
  localparam int SAMPLE_NS    = 1000;      // One new angle per microsecond
  localparam int CLK_NS       = 100;       // System clock period
  localparam int SAMPLE_CYC   = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILT_SHIFT   = 3;         // Filter time constant as a shift
  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  localparam int REG_DEPTH    = 32;        // Five-bit address space
  localparam logic [4:0] REG_ZERO_LO = 5'h00; // Zero reference low byte
  localparam logic [4:0] REG_ZERO_HI = 5'h01; // Zero reference high byte
  localparam logic [4:0] REG_DIR     = 5'h09; // Rotation direction in bit 7
  localparam int DIR_BIT      = 7;         // Direction flag position
  localparam logic [7:0] REG_RESET   = 8'h00; // Register reset value
  // ---------------------------------------------------------------
  // Frame kinds
  // ---------------------------------------------------------------
  typedef enum {ASS_ANGLE, ASS_REG_READ, ASS_REG_WRITE} ass_kind_t;
endpackage : ass_pkg

// [ass_regmem.sv]
module ass_regmem #(
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic          clk_i,     // System clock
  input  wire logic          nrst_i,    // Asynchronous reset, low active
  input  wire logic          ce_i,      // Clock enable
  input  wire logic          we_i,      // Write strobe
  input  wire logic [AW-1:0] waddr_i,   // Write address
  input  wire logic [7:0]    wdata_i,   // Write data
  input  wire logic [AW-1:0] raddr_i,   // Read address
  output logic      [7:0]    rdata_o    // Registered read data
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0] mem [DEPTH];              // Register words

  if (DEPTH > (1 << AW))
  begin : g_bad_depth
    $error("ass_regmem: depth exceeds address range");
  end

  // Write and registered read; reset clears every word
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= ass_pkg::REG_RESET;
      rdata_o <= 8'h00;
    end
    else if (ce_i)
    begin
      if (we_i) mem[waddr_i] <= wdata_i;
      rdata_o <= mem[raddr_i];
    end
  end

  // Checks: a write lands in its word, the read register follows the array
  mem_write_a : assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i && we_i |=> mem[$past(waddr_i)] == $past(wdata_i)) else $error("write did not land");
  read_data_a : assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i |=> rdata_o == $past(mem[raddr_i])) else $error("read data not registered");
  read_hold_a : assert property (@(posedge clk_i) disable iff (!nrst_i)
    !ce_i |=> $stable(rdata_o)) else $error("read data moved while disabled");
endmodule : ass_regmem

// [ass_spi_slave.sv]
// Overview of operation
// - New angle sample taken every microsecond
// - Second-order smoothing of raw samples
// - Default angle rises with clockwise field
// - Direction and zero reference are programmable
// - Mode 0 and 3 work without configuration
// - Every command is sixteen bits
// - Sample rising, shift falling, MSB first
// - Angle read, register read, register write
// - Buffer loads per microsecond, frozen while selected
// - Angle sent MSB first, zero padded
// - Read command returns value next frame
// - Write command echoes stored value next frame
module ass_spi_slave #(
  parameter int ANGLE_W = ass_pkg::ANGLE_BITS
) (
  input  wire logic        MCLK_I,       // System clock, 10 MHz
  input  wire logic        NRST_I,       // Asynchronous reset, low active
  input  wire logic        CE_I,         // Clock enable, freezes system side
  input  wire logic [15:0] RAW_ANGLE_I,  // Raw front-end angle
  input  wire logic        SCLK_I,       // Link clock from the master
  input  wire logic        CS_N_I,       // Chip select, low active
  input  wire logic        MOSI_I,       // Serial data in
  output logic             MISO_O,       // Serial data out
  output logic             MISO_OE_O,    // MISO drive enable
  output logic [15:0]      ANGLE_O       // Filtered, corrected angle
);
  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (ANGLE_W < 1 || ANGLE_W > 16)
  begin : g_bad_width
    $error("ass_spi_slave: bad angle width");
  end

  // ---------------------------------------------------------------
  // Sample tick and filter, system domain
  // ---------------------------------------------------------------
  logic [3:0]  tick_cnt;                 // Microsecond divider
  logic        tick;                     // One-cycle sample strobe
  logic [15:0] raw_s;                    // Captured raw sample
  logic signed [31:0] y1, y2;            // Two cascaded lag stages, scaled
  logic [15:0] filt;                     // Filtered angle
  logic [15:0] zero_ref;                 // Programmed zero reference
  logic        dir_ccw;                  // Programmed reverse direction
  wire  [15:0] oriented = dir_ccw ? 16'(-filt) : filt;
  wire  [15:0] corrected = 16'(oriented - zero_ref);
  wire  [15:0] quantized = corrected & ~16'((17'h10000 >> ANGLE_W) - 17'h1);
  wire  signed [31:0] x_s = {raw_s, 16'h0000} >>> 1;
  wire  signed [31:0] d1 = x_s - y1;
  wire  signed [31:0] next_y1 = y1 + (d1 >>> ass_pkg::FILT_SHIFT);
  // Lead term keeps steady-speed lag at zero: out = 2*y1 - y2
  wire  signed [31:0] next_y2 = y2 + ((y1 - y2) >>> ass_pkg::FILT_SHIFT);
  wire  signed [31:0] lead = (y1 <<< 1) - y2;

  assign tick = (tick_cnt == 4'(ass_pkg::SAMPLE_CYC - 1));

  // Divider for the one-microsecond sample strobe
  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I) tick_cnt <= 4'h0;
    else if (CE_I) tick_cnt <= tick ? 4'h0 : 4'(tick_cnt + 4'h1);
  end
  tick_spacing_a : assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    CE_I && tick |=> !tick && tick_cnt == 4'h0) else $error("sample strobe out of step");

  // Raw input is on the system clock and needs no synchroniser
  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      raw_s <= 16'h0000;
      y1    <= 32'sh0;
      y2    <= 32'sh0;
      filt  <= 16'h0000;
    end
    else if (CE_I && tick)
    begin
      raw_s <= RAW_ANGLE_I;
      y1    <= next_y1;
      y2    <= next_y2;
      filt  <= 16'(lead >>> 15);
    end
  end

  // Output buffer refreshed each microsecond unless frozen by the link
  logic [15:0] obuf;                     // Angle buffer read by the link
  logic [2:0]  cs_sync;                  // Chip select synchroniser plus history
  wire         sel_s = ~cs_sync[1];      // Selected, system view
  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      cs_sync <= 3'h7;
      obuf    <= 16'h0000;
      ANGLE_O <= 16'h0000;
    end
    else if (CE_I)
    begin
      cs_sync <= {cs_sync[1:0], CS_N_I};
      if (tick && !sel_s && cs_sync[2]) obuf <= quantized;
      ANGLE_O <= quantized;
    end
  end
  obuf_frozen_a : assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    sel_s |=> $stable(obuf)) else $error("angle buffer moved while selected");

  // ---------------------------------------------------------------
  // Link domain: shift in on rising, out on falling SCLK
  // ---------------------------------------------------------------
  // Mode 0 shows its first bit before any edge, mode 3 launches it on the
  // first fall; a fall that comes before any rise marks mode 3.
  logic [4:0]  bit_cnt;                  // Bits received this frame
  logic [14:0] sh_in;                    // Received bits
  logic [15:0] sh_out;                   // Transmit shift register
  logic        reply_pend;               // Next frame returns a register value
  logic [7:0]  reply_val;                // Value for the next frame
  logic        frame_tog;                // Toggles on each full command frame
  logic [15:0] frame_word;               // Last full command word
  wire  [15:0] rx_word = {sh_in, MOSI_I};
  wire         last_bit = (bit_cnt == 5'(ass_pkg::FRAME_BITS - 1));

  // Frame assembly; chip select high resets the frame asynchronously
  always_ff @(posedge SCLK_I or posedge CS_N_I)
  begin
    if (CS_N_I)
    begin
      bit_cnt <= 5'h00;
      sh_in   <= 15'h0000;
    end
    else if (!last_bit && bit_cnt != 5'h10)
    begin
      bit_cnt <= 5'(bit_cnt + 5'h01);
      sh_in   <= rx_word[14:0];
    end
    else if (last_bit)
      bit_cnt <= 5'h10;
  end

  // Completed frames pass as a toggle and a stable word
  always_ff @(posedge SCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      frame_tog  <= 1'b0;
      frame_word <= 16'h0000;
    end
    else if (!CS_N_I && last_bit)
    begin
      frame_tog  <= ~frame_tog;
      frame_word <= rx_word;
    end
  end

  // Falling edge launch; the first fall picks the mode from the rises seen
  logic [15:0] tx_src;                   // Word for the coming frame
  logic        launched;                 // A falling edge has come this frame
  wire         first_fall = !launched;
  wire         mode3 = (bit_cnt == 5'h00); // No rise yet: clock idled high
  always_ff @(negedge SCLK_I or posedge CS_N_I)
  begin
    if (CS_N_I) sh_out <= 16'h0000;
    else if (first_fall && mode3) sh_out <= tx_src;
    else if (first_fall) sh_out <= {tx_src[14:0], 1'b0};
    else sh_out <= {sh_out[14:0], 1'b0};
  end
  assign tx_src = reply_pend ? {reply_val, 8'h00} : obuf;

  // Shifting starts at the first fall; before it the source's top bit shows
  always_ff @(negedge SCLK_I or posedge CS_N_I)
  begin
    if (CS_N_I) launched <= 1'b0;
    else launched <= 1'b1;
  end
  // Driven for the whole selection, so mode 0 has its first bit before any edge
  assign MISO_OE_O = ~CS_N_I;
  always_comb MISO_O = launched ? sh_out[15] : tx_src[15];

  // ---------------------------------------------------------------
  // Command decode, system domain, through the two-entry buffer
  // ---------------------------------------------------------------
  logic [2:0]  tog_sync;                 // Frame toggle synchroniser
  wire         frame_evt = tog_sync[2] ^ tog_sync[1];
  logic [15:0] q_word [2];               // Two-entry command buffer
  logic [1:0]  q_cnt;                    // Entries held
  logic        q_rd;                     // Buffer read pointer
  logic        q_wr;                     // Buffer write pointer
  wire         q_in_valid = frame_evt;
  wire         q_in_ready = (q_cnt != 2'h2);
  wire         q_out_valid = (q_cnt != 2'h0);
  logic        q_out_ready;              // Decoder takes a word
  wire  [15:0] cmd_word = q_word[q_rd];
  wire  [2:0]  cmd = cmd_word[ass_pkg::CMD_MSB:ass_pkg::CMD_LSB];
  wire  [4:0]  cmd_addr = cmd_word[ass_pkg::ADDR_MSB:ass_pkg::ADDR_LSB];
  wire         is_wr = (cmd == ass_pkg::CMD_WRITE);
  wire         is_rd = (cmd == ass_pkg::CMD_READ);
  wire         push = q_in_valid && q_in_ready;
  wire         pop = q_out_valid && q_out_ready;
  logic [1:0]  rd_wait;                  // Memory read latency
  logic [4:0]  cur_addr;                 // Address being answered
  logic [7:0]  mem_q;                    // Registered memory data

  assign q_out_ready = (rd_wait == 2'h0);

  // Buffer bookkeeping
  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      tog_sync <= 3'h0;
      q_cnt <= 2'h0;
      q_rd <= 1'b0;
      q_wr <= 1'b0;
      q_word[0] <= 16'h0000;
      q_word[1] <= 16'h0000;
    end
    else if (CE_I)
    begin
      tog_sync <= {tog_sync[1:0], frame_tog};
      if (push) q_word[q_wr] <= frame_word;
      if (push) q_wr <= ~q_wr;
      if (pop) q_rd <= ~q_rd;
      q_cnt <= 2'(q_cnt + {1'b0, push} - {1'b0, pop});
    end
  end

  // Decode: read and write commands arm a reply; other words are angle reads
  logic        arm;                      // Reply armed, system side
  logic [7:0]  arm_val;                  // Reply value, system side
  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      rd_wait <= 2'h0;
      cur_addr <= 5'h00;
      arm <= 1'b0;
      arm_val <= 8'h00;
      zero_ref <= 16'h0000;
      dir_ccw <= 1'b0;
    end
    else if (CE_I)
    begin
      if (pop && (is_rd || is_wr))
      begin
        rd_wait <= 2'h2;
        cur_addr <= cmd_addr;
      end
      else if (pop) arm <= 1'b0;
      else if (rd_wait != 2'h0) rd_wait <= 2'(rd_wait - 2'h1);
      if (rd_wait == 2'h1)
      begin
        arm <= 1'b1;
        arm_val <= mem_q;
      end
      if (pop && is_wr && cmd_addr == ass_pkg::REG_ZERO_LO) zero_ref[7:0] <= cmd_word[7:0];
      if (pop && is_wr && cmd_addr == ass_pkg::REG_ZERO_HI) zero_ref[15:8] <= cmd_word[7:0];
      if (pop && is_wr && cmd_addr == ass_pkg::REG_DIR)
        dir_ccw <= cmd_word[ass_pkg::DIR_BIT];
    end
  end
  sequence wr_pop_s; CE_I && pop && is_wr; endsequence
  sequence echo_armed_s; ##3 arm && arm_val == $past(cmd_word[7:0], 3); endsequence
  write_echo_a : assert property (@(posedge MCLK_I) disable iff (!NRST_I || !CE_I)
    wr_pop_s |-> echo_armed_s) else $error("write echo not armed");

  // Register storage; the echo reads back the stored word
  ass_regmem #(.DEPTH(ass_pkg::REG_DEPTH), .AW(5)) u_mem (
    .clk_i   (MCLK_I),
    .nrst_i  (NRST_I),
    .ce_i    (CE_I),
    .we_i    (pop && is_wr),
    .waddr_i (cmd_addr),
    .wdata_i (cmd_word[ass_pkg::VAL_MSB:0]),
    .raddr_i (cur_addr),
    .rdata_o (mem_q)
  );

  // Reply state taken at the chip-select fall; the master's idle time lets it settle
  always_ff @(negedge CS_N_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      reply_pend <= 1'b0;
      reply_val <= 8'h00;
    end
    else
    begin
      reply_pend <= arm;
      reply_val <= arm_val;
    end
  end
endmodule : ass_spi_slave

// [ass_spi_master.sv]
module ass_spi_master (
  output logic      sclk_o,    // Link clock, still between frames except while noise runs
  output logic      cs_n_o,    // Chip select, low active
  output logic      mosi_o,    // Command bits to the device
  input  wire logic miso_i,    // Device data
  input  wire logic miso_oe_i  // Device drive enable
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // Line resolution
  // ---------------------------------------------------------------
  logic last;                  // Last level the device drove
  wire  line;                  // Level the master really sees
  // Undriven line shows the opposite of the last bit, never a lucky match
  assign line = miso_oe_i ? miso_i : ~last;
  // Track the driven level
  always @(miso_i or miso_oe_i)
  begin
    if (miso_oe_i)
      last = miso_i;
  end
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;             // Chip select idles high
    mosi_o = 1'b0;
    last = 1'b0;
  end
  // ---------------------------------------------------------------
  // One frame; half is the half period, at least 20 ns
  // ---------------------------------------------------------------
  task automatic frame(input logic cpol, input int half, input int nbits,
                       input logic [15:0] tx, input int gap, output logic [15:0] rx);
    rx = 16'h0000;
    sclk_o = cpol;             // Idle level picks the mode
    #100;
    cs_n_o = 1'b0;
    #80;
    for (int i = 0; i < nbits; i++)
    begin
      if (cpol || i > 0)
        sclk_o = 1'b0;
      mosi_o = tx[15-i];       // Changed after the falling edge, MSB first
      #half;
      rx[15-i] = line;         // Taken at the rising edge
      sclk_o = 1'b1;
      #half;
    end
    #25;
    sclk_o = cpol;
    #25;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
    #gap;                      // Idle before the next frame
  endtask : frame
  // Clock and data wiggle with chip select high
  task automatic noise(input logic [15:0] tx);
    for (int i = 0; i < 16; i++)
    begin
      mosi_o = tx[15-i];
      #20;
      sclk_o = 1'b1;
      #20;
      sclk_o = 1'b0;
    end
    mosi_o = 1'b0;
  endtask : noise
endmodule : ass_spi_master

// [tb_angle_sensor_spi_slave.sv]
module tb_angle_sensor_spi_slave;
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam logic [15:0] TOL = 16'h0040;  // Filter rounding allowance
  localparam int angle_read_gap = 150;     // Gap between angle reads
  localparam int register_read_gap = 1000; // Gap around register reads
  // Shortened: the design commits writes at once
  localparam int nonvolatile_write_wait = 20000;
  logic mclk = 1'b0;                       // System clock
  logic rst_n = 1'b0;                      // Reset, low active
  logic ce = 1'b1;                         // System clock enable
  logic [15:0] raw = 16'h0000;             // Front-end angle
  logic sclk, cs_n, mosi, miso, miso_oe;   // Link wires
  logic [15:0] angle;                      // Filtered angle
  int fails = 0;
  int num_checks = 0;
  always #50 mclk = ~mclk;
  ass_spi_slave DUT (.MCLK_I(mclk), .NRST_I(rst_n), .CE_I(ce), .RAW_ANGLE_I(raw),
    .SCLK_I(sclk), .CS_N_I(cs_n), .MOSI_I(mosi), .MISO_O(miso), .MISO_OE_O(miso_oe),
    .ANGLE_O(angle));
  ass_spi_master u_master (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso),
    .miso_oe_i(miso_oe));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Modular distance, so wrap at zero is not a miss
  function automatic logic near(input logic [15:0] a, input logic [15:0] b,
                                input logic [15:0] tol);
    logic [15:0] d;
    d = a - b;
    return (d <= tol) || ((16'h0000 - d) <= tol);
  endfunction : near
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] tol);
    num_checks++;
    if (near(got, exp, tol) !== 1'b1)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask : chk
  // New raw angle, then let the filter settle
  task automatic settle(input logic [15:0] v);
    @(negedge mclk) raw = v;
    repeat (3000) @(posedge mclk);
  endtask : settle
  task automatic reg_rd(input logic [4:0] a, output logic [15:0] rx);
    logic [15:0] d;
    u_master.frame(0, 20, 16, {ass_pkg::CMD_READ, a, 8'h00}, register_read_gap, d);
    u_master.frame(0, 20, 16, 16'h0000, register_read_gap, rx);
  endtask : reg_rd
  task automatic reg_wr(input logic [4:0] a, input logic [7:0] v, output logic [15:0] rx);
    logic [15:0] d;
    u_master.frame(0, 20, 16, {ass_pkg::CMD_WRITE, a, v}, nonvolatile_write_wait, d);
    u_master.frame(0, 20, 16, 16'h0000, register_read_gap, rx);
  endtask : reg_wr
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_defaults();
    logic [15:0] rx;
    logic [4:0] a[3];
    a = '{ass_pkg::REG_ZERO_LO, ass_pkg::REG_ZERO_HI, ass_pkg::REG_DIR};
    for (int i = 0; i < 3; i++)
    begin
      reg_rd(a[i], rx);
      chk(rx, {ass_pkg::REG_RESET, 8'h00}, 0);
    end
    chk({15'h0, miso_oe}, 0, 0);
    $display("test defaults done");
  endtask : t_defaults
  // In each mode, a full read then a short read, back to back
  task automatic t_angle();
    logic [15:0] rx;
    settle(16'h3a5c);
    chk(angle, 16'h3a5c, TOL);
    for (int m = 0; m < 2; m++)
    begin
      u_master.frame(m[0], 20, 16, 16'h0000, angle_read_gap, rx);
      chk(rx, 16'h3a5c, TOL);
      chk(rx & 16'h0003, 0, 0);
      u_master.frame(m[0], 20, 8, 16'h0000, angle_read_gap, rx);
      chk(rx, 16'h3a5c, 16'h0100);
    end
    $display("test angle done");
  endtask : t_angle
  // Slow frame; raw jumps while selected
  task automatic t_freeze();
    logic [15:0] rx;
    fork
      u_master.frame(0, 60, 16, 16'h0000, angle_read_gap, rx);
      begin
        #300;
        @(negedge mclk) raw = 16'hba5c;
      end
    join
    chk(rx, 16'h3a5c, TOL);
    settle(16'hba5c);
    chk(angle, 16'hba5c, TOL);
    settle(16'h3a5c);
    $display("test freeze done");
  endtask : t_freeze
  task automatic t_program();
    logic [15:0] rx;
    reg_wr(ass_pkg::REG_ZERO_HI, 8'h10, rx);
    chk(rx, 16'h1000, 0);
    settle(16'h3a5c);
    chk(angle, 16'h2a5c, TOL);
    reg_wr(ass_pkg::REG_DIR, 8'h80, rx);
    chk(rx, 16'h8000, 0);
    settle(16'h3a5c);
    chk(angle, 16'hb5a4, TOL);
    reg_rd(ass_pkg::REG_DIR, rx);
    chk(rx, 16'h8000, 0);
    reg_wr(ass_pkg::REG_DIR, 8'h00, rx);
    reg_wr(ass_pkg::REG_ZERO_HI, 8'h00, rx);
    chk(rx, 16'h0000, 0);
    $display("test program done");
  endtask : t_program
  // Clock enable low freezes the angle path while the raw input moves
  task automatic t_hold();
    @(negedge mclk);
    ce = 1'b0;
    raw = 16'hba5c;
    repeat (50) @(negedge mclk);
    chk(angle, 16'h3a5c, TOL);
    raw = 16'h3a5c;
    ce = 1'b1;
    repeat (50) @(negedge mclk);
    chk(angle, 16'h3a5c, TOL);
    $display("test hold done");
  endtask : t_hold
  // A write pattern clocked with chip select high must do nothing
  task automatic t_deselect();
    logic [15:0] rx;
    int bad;
    bad = 0;
    fork
      u_master.noise({ass_pkg::CMD_WRITE, ass_pkg::REG_DIR, 8'hff});
      repeat (16) @(posedge sclk) if (miso_oe !== 1'b0) bad++;
    join
    chk(bad[15:0], 0, 0);
    reg_rd(ass_pkg::REG_DIR, rx);
    chk(rx, 16'h0000, 0);
    $display("test deselect done");
  endtask : t_deselect
  // ---------------------------------------------------------------
  // Verdict and sequence
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // Watchdog well past the expected run
  initial
  begin
    #4000000;
    fails++;
    end_sim();
  end
  initial
  begin
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_angle();
    t_defaults();
    t_freeze();
    t_program();
    t_hold();
    t_deselect();
    end_sim();
  end
endmodule : tb_angle_sensor_spi_slave
